/* dv/micro_triangle_opacity_resolver_tb.sv */
// Testbench for the opacity resolver with a reference model.
// Assumes a 25 MHz clock and the pass-through and lookup latencies of the resolver.
`timescale 1ns/1ps
`default_nettype none
module micro_triangle_opacity_resolver_tb;
    logic clock = 0, rst = 1, clk_en = 1, mask_we = 0, req = 0, non_opaque = 0, two_bit = 0;
    logic [11:0] mask_waddr = 12'h000;
    logic [1:0] mask_wdata = 2'h0;
    logic [3:0] level = 4'h0;
    logic [15:0] bary_u = 16'h0000, bary_v = 16'h0000;
    logic [23:0] mask_base = 24'h00_0000, tri_index;
    logic busy, done, hit, cont, to_shader_processor;
    logic [1:0] mem [4096];
    int err_count = 0, n_checks = 0, shaders = 0, runs, seed = 32'h0000_ce88, d;
    always #20 clock = ~clock;
    opacity_resolver dut (.clock(clock), .rst(rst), .clk_en(clk_en), .mask_we(mask_we),
        .mask_waddr(mask_waddr), .mask_wdata(mask_wdata), .req(req), .non_opaque(non_opaque),
        .two_bit(two_bit), .level(level), .bary_u(bary_u), .bary_v(bary_v),
        .mask_base(mask_base), .busy(busy), .done(done), .hit(hit), .cont(cont),
        .to_shader_processor(to_shader_processor), .tri_index(tri_index));
    shader_model partner (.clock(clock), .rst(rst), .done(done),
        .to_shader_processor(to_shader_processor), .runs(runs));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic resolve(input logic no, input logic tb, input logic [3:0] lv,
        input logic [15:0] u, input logic [15:0] v, input logic [23:0] b);
        int sh, row, col, fu, fv, n, e;
        logic [23:0] idx;
        logic [1:0] s;
        sh = 16 - lv;
        row = v >> sh;
        col = u >> sh;
        fu = u & ((1 << sh) - 1);
        fv = v & ((1 << sh) - 1);
        idx = 24'(row * row + 2 * col + int'((fu + fv) >= (1 << sh)) + b);
        s = mem[idx[11:0]];
        e = !no ? 4 : (tb && s[1]) ? 1 : (s[0] ? 4 : 2);
        @(posedge clock);
        req <= 1;
        non_opaque <= no;
        two_bit <= tb;
        level <= lv;
        bary_u <= u;
        bary_v <= v;
        mask_base <= b;
        @(posedge clock);
        req <= 0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
            if (n == 1 && no) check(busy, 1, "busy");
        end while (done !== 1'b1 && n < 10);
        check(n, no ? 3 : 1, "latency");
        check({hit, cont, to_shader_processor}, e, "outcome");
        check(tri_index, no ? idx : 24'h00_0000, "index");
        if (e == 1) shaders++;
    endtask : resolve
    task automatic frozen;
        logic [1:0] s;
        int e;
        s = mem[0];
        e = s[1] ? 1 : (s[0] ? 4 : 2);
        @(posedge clock);
        req <= 1;
        non_opaque <= 1;
        two_bit <= 1;
        level <= 4'h0;
        bary_u <= 16'h0000;
        bary_v <= 16'h0000;
        mask_base <= 24'h00_0000;
        @(posedge clock);
        clk_en <= 0;
        repeat (3) begin
            @(negedge clock);
            check({busy, done}, 2, "frozen lookup");
        end
        @(posedge clock);
        clk_en <= 1;
        @(posedge clock);
        req <= 0;
        repeat (2) @(negedge clock);
        check(done, 1, "frozen result");
        check({hit, cont, to_shader_processor}, e, "frozen outcome");
        @(negedge clock);
        check({done, busy}, 0, "req refused while busy");
        if (e == 1) shaders++;
    endtask : frozen
    initial begin
        repeat (20) @(posedge clock);
        rst <= 0;
        for (int i = 0; i < 4096; i++) begin
            @(posedge clock);
            d = $random(seed);
            mask_we <= 1;
            mask_waddr <= i[11:0];
            mask_wdata <= d[1:0];
            mem[i] = d[1:0];
        end
        @(posedge clock);
        mask_we <= 0;
        resolve(1, 1, 4'h0, 16'h0000, 16'h0000, 24'h00_0000);
        resolve(1, 0, 4'hc, 16'hffff, 16'h0000, 24'hff_ffff);
        frozen;
        for (int i = 0; i < 400; i++) begin
            d = $random(seed);
            resolve(d[0], d[1], 4'({$random(seed)} % 13), d[31:16],
                16'({$random(seed)} % (17'h1_0000 - d[31:16])), 24'($random(seed)));
        end
        repeat (2) @(posedge clock);
        check(runs, shaders, "shader runs");
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        final_report;
    end
endmodule : micro_triangle_opacity_resolver_tb
`default_nettype wire

/* dv/shader_model.sv */
// Shader processor stand-in that counts hit-shader launches.
// Assumes one-cycle result pulses from the resolver.
`timescale 1ns/1ps
`default_nettype none
module shader_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Hand-off from resolver
    input wire logic done,
    input wire logic to_shader_processor,
    // Launch count
    output int runs
);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) runs <= 0;
        else if (done && to_shader_processor) runs <= runs + 1;
    end
endmodule : shader_model
`default_nettype wire

/* rtl/opacity_decode.sv */
// Decodes stored opacity bits into a decision.
// Assumes stored bits come from the mask memory.
`timescale 1ns/1ps
`default_nettype none
module opacity_decode (
    // Mask format
    input wire logic two_bit,
    // Stored state
    input wire logic [1:0] state_bits,
    // Result
    output opacity_pkg::decision_t decision
);
    always_comb begin
        if (!two_bit) begin
            // One bit: opaque or transparent only
            decision = state_bits[0] ? opacity_pkg::DEC_HIT : opacity_pkg::DEC_IGNORE;
        end else if (state_bits == opacity_pkg::ENC_OPAQUE) begin
            decision = opacity_pkg::DEC_HIT;
        end else if (state_bits == opacity_pkg::ENC_TRANSPARENT) begin
            decision = opacity_pkg::DEC_IGNORE;
        end else begin
            decision = opacity_pkg::DEC_SHADER;
        end
    end
endmodule : opacity_decode
`default_nettype wire

/* rtl/opacity_pkg.sv */
// Constants and types shared by the opacity resolver.
// Assumes a single 25 MHz clock domain.
package opacity_pkg;
    localparam int LEVEL_W = 4;
    localparam int MAX_LEVEL = 12;
    localparam int COORD_W = 16;
    localparam int INDEX_W = 24;
    localparam int MASK_DEPTH = 4096;
    localparam int ADDR_W = 12;
    localparam logic [1:0] ENC_TRANSPARENT = 2'h0;
    localparam logic [1:0] ENC_OPAQUE = 2'h1;
    localparam logic [1:0] ENC_UNKNOWN_A = 2'h2;
    localparam logic [1:0] ENC_UNKNOWN_B = 2'h3;
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam int LOOKUP_CYCLES = 2;
    typedef enum logic [1:0] {
        DEC_HIT,
        DEC_IGNORE,
        DEC_SHADER,
        DEC_NONE
    } decision_t;
endpackage : opacity_pkg

/* rtl/opacity_resolver.sv */
// Micro-triangle opacity resolver for intersections with non-opaque triangles.
// Assumes traversal holds request inputs stable while req is high and busy is low.
`timescale 1ns/1ps
`default_nettype none
module opacity_resolver (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // Mask memory load
    input wire logic mask_we,
    input wire logic [opacity_pkg::ADDR_W-1:0] mask_waddr,
    input wire logic [1:0] mask_wdata,
    // Request from traversal
    input wire logic req,
    input wire logic non_opaque,
    input wire logic two_bit,
    input wire logic [opacity_pkg::LEVEL_W-1:0] level,
    input wire logic [opacity_pkg::COORD_W-1:0] bary_u,
    input wire logic [opacity_pkg::COORD_W-1:0] bary_v,
    input wire logic [opacity_pkg::INDEX_W-1:0] mask_base,
    // Results
    output logic busy,
    output logic done,
    output logic hit,
    output logic cont,
    output logic to_shader_processor,
    output logic [opacity_pkg::INDEX_W-1:0] tri_index
);
    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_DECIDE} state_t;

    logic [1:0] mask_mem [opacity_pkg::MASK_DEPTH];
    state_t state_q, state_d;
    logic [opacity_pkg::INDEX_W-1:0] idx_q, idx_d;
    logic [1:0] bits_q, bits_d;
    logic fmt_q, fmt_d;
    logic busy_q, busy_d, done_q, done_d, hit_q, hit_d, cont_q, cont_d, shd_q, shd_d;
    opacity_pkg::decision_t dec;
    logic [opacity_pkg::COORD_W-1:0] iu, iv, row, col;
    logic [opacity_pkg::INDEX_W-1:0] local_idx;
    logic upper;
    logic [opacity_pkg::COORD_W-1:0] frac_u, frac_v;
    logic [opacity_pkg::COORD_W:0] frac_sum;

    opacity_decode u_decode (
        .two_bit(fmt_q),
        .state_bits(bits_q),
        .decision(dec)
    );

    // Grid cell coordinates from barycentrics at the mask level
    always_comb begin
        iu = bary_u >> (opacity_pkg::COORD_W - int'(level));
        iv = bary_v >> (opacity_pkg::COORD_W - int'(level));
        row = iv;
        col = iu;
        upper = 1'b0;
        if (level == '0) begin
            iu = '0;
            iv = '0;
            row = '0;
            col = '0;
        end
        // Fractional parts decide upright or inverted micro-triangle
        frac_u = bary_u << level;
        frac_v = bary_v << level;
        frac_sum = {1'b0, frac_u} + {1'b0, frac_v};
        upper = (level != '0) && frac_sum[opacity_pkg::COORD_W];
        // Index: rows before plus column pair offset
        local_idx = opacity_pkg::INDEX_W'(row) * opacity_pkg::INDEX_W'(row)
            + opacity_pkg::INDEX_W'({col, 1'b0}) + opacity_pkg::INDEX_W'(upper);
    end

    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        bits_d = bits_q;
        fmt_d = fmt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        hit_d = 1'b0;
        cont_d = 1'b0;
        shd_d = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (req) begin
                    if (!non_opaque) begin
                        done_d = 1'b1;
                        hit_d = 1'b1;
                        idx_d = '0;
                    end else begin
                        idx_d = mask_base + local_idx;
                        fmt_d = two_bit;
                        busy_d = 1'b1;
                        state_d = S_FETCH;
                    end
                end
            end
            S_FETCH: begin
                bits_d = mask_mem[idx_q[opacity_pkg::ADDR_W-1:0]];
                state_d = S_DECIDE;
            end
            S_DECIDE: begin
                done_d = 1'b1;
                busy_d = 1'b0;
                hit_d = (dec == opacity_pkg::DEC_HIT);
                cont_d = (dec == opacity_pkg::DEC_IGNORE);
                shd_d = (dec == opacity_pkg::DEC_SHADER);
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (clk_en && mask_we) begin
            mask_mem[mask_waddr] <= mask_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            idx_q <= '0;
            bits_q <= '0;
            fmt_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            hit_q <= 1'b0;
            cont_q <= 1'b0;
            shd_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            idx_q <= idx_d;
            bits_q <= bits_d;
            fmt_q <= fmt_d;
            busy_q <= busy_d;
            done_q <= done_d;
            hit_q <= hit_d;
            cont_q <= cont_d;
            shd_q <= shd_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign hit = hit_q;
    assign cont = cont_q;
    assign to_shader_processor = shd_q;
    assign tri_index = idx_q;

    // Checks
    one_result_a: assert property (@(posedge clock) disable iff (rst)
        done |-> $onehot({hit, cont, to_shader_processor}))
        else $error("result not one-hot");
    result_done_a: assert property (@(posedge clock) disable iff (rst)
        (hit || cont || to_shader_processor) |-> done)
        else $error("result bit without done");
    opaque_pass_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_IDLE && req && !non_opaque) |=> (done && hit))
        else $error("opaque triangle not passed");
    pass_index_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_IDLE && req && !non_opaque) |=> (tri_index == '0 && !busy))
        else $error("pass-through looked up");
    lookup_time_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_IDLE && req && non_opaque) ##1 clk_en ##1 clk_en |=> done)
        else $error("lookup too slow");
    fmt_latch_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_IDLE && req && non_opaque) |=> (busy && fmt_q == $past(two_bit)))
        else $error("mask format not latched");
    busy_span_a: assert property (@(posedge clock) disable iff (rst)
        (state_q != S_IDLE) |-> busy)
        else $error("lookup without busy");
    refuse_busy_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_FETCH && req) |=> (state_q == S_DECIDE))
        else $error("request taken while busy");
    frozen_state_a: assert property (@(posedge clock) disable iff (rst)
        !clk_en |=> ($stable(state_q) && $stable(busy) && $stable(done) && $stable(tri_index)))
        else $error("state moved while disabled");
    decide_done_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_DECIDE) |=> (done && !busy && state_q == S_IDLE))
        else $error("decision not finished");
    one_bit_a: assert property (@(posedge clock) disable iff (rst)
        (done && !fmt_q) |-> !to_shader_processor)
        else $error("one-bit gave unknown");
    opaque_hit_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_DECIDE && dec == opacity_pkg::DEC_HIT) |=> hit)
        else $error("opaque not hit");
    transp_cont_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_DECIDE && dec == opacity_pkg::DEC_IGNORE) |=> (cont && !hit))
        else $error("transparent not ignored");
    unknown_shd_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_DECIDE && fmt_q && bits_q[1]) |=> to_shader_processor)
        else $error("unknown not handed over");
    busy_clear_a: assert property (@(posedge clock) disable iff (rst)
        done |-> !busy)
        else $error("busy with done");
    index_base_a: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == S_IDLE && req && non_opaque) |=> (tri_index == $past(mask_base) + $past(local_idx)))
        else $error("bad index");

    // Coverage
    cov_hit_c: cover property (@(posedge clock)
        done && hit && busy == 1'b0 && fmt_q);
    cov_cont_c: cover property (@(posedge clock)
        done && cont);
    cov_shd_c: cover property (@(posedge clock)
        done && to_shader_processor);
    cov_pass_c: cover property (@(posedge clock)
        done && hit && tri_index == '0);
    cov_freeze_c: cover property (@(posedge clock)
        !clk_en && busy);
endmodule : opacity_resolver
`default_nettype wire
